/* File: rtl/lin_uart.sv */
// top of the serial transceiver with break support
// Summary of operation
// - A 20-bit divider makes the tick pacing transmit and receive.
// - Each received bit spans a programmable number of sample ticks.
// - Fifo depths are build parameters, held between 16 and 1024.
// - With the status fifo built, data and status fifos are 512 maximum.
// - Transmitter pops the oldest character, computes parity, tracks empty/full.
// - Receiver filters input, shifts characters in, pushes them into fifo.
// - Character length is five, six, seven or eight bits.
// - Stop length is one, one and a half, or two bits.
// - Parity none, even, odd, space or mark, on both directions.
// - Receiver flags framing errors, parity errors and line breaks.
// - Software can hold the transmit line low as a break.
// - Clear-to-send and request-to-send handled automatically or by software.
// - Programmable receive, transmit and request-to-send fill thresholds.
// - Transmitter idle only when shifter and transmit fifo are empty.
// - Interrupt asserts only for an enabled, holding condition.
// - Interrupt is a level, active high, while any enabled condition holds.
// - Fill levels of both fifos are readable.
// - Channel reset, and separate receive and transmit pointer resets.
// - Outputs for transmit almost empty and receive almost full.
// - Terminal-ready output; set-ready, ring and carrier inputs observable.
// - Settings and data are reached by the processor through plain ports.
// - Fifos have one port per side, used concurrently.
`timescale 1ns/1ps
`default_nettype none
module lin_uart #(
	parameter int TX_DEPTH = 256,
	parameter int RX_DEPTH = 256,
	parameter bit USE_STAT = 1'b1,
	parameter logic [uart_pkg::DIV_W-1:0] INIT_BAUD_DIV = uart_pkg::RST_BAUD_DIV,
	parameter logic [uart_pkg::SAMP_W-1:0] INIT_SAMPLES = uart_pkg::RST_SAMPLES,
	parameter logic [1:0] INIT_LEN = uart_pkg::RST_LEN,
	parameter logic [1:0] INIT_STOP = uart_pkg::RST_STOP,
	parameter logic [2:0] INIT_PARITY = uart_pkg::RST_PARITY,
	parameter logic [uart_pkg::LVL_W-1:0] INIT_RX_TRIG = uart_pkg::RST_RX_TRIG,
	parameter logic [uart_pkg::LVL_W-1:0] INIT_TX_TRIG = uart_pkg::RST_TX_TRIG,
	parameter logic [uart_pkg::LVL_W-1:0] INIT_RTS_TRIG = uart_pkg::RST_RTS_TRIG
) (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic soft_rst_in,
	input wire logic rx_ptr_rst_in,
	input wire logic tx_ptr_rst_in,
	input wire logic cfg_wr_in,
	input wire logic [uart_pkg::DIV_W-1:0] baud_div_in,
	input wire logic [uart_pkg::SAMP_W-1:0] samples_in,
	input wire logic [1:0] data_len_in,
	input wire logic [1:0] stop_sel_in,
	input wire logic [2:0] parity_in,
	input wire logic break_in,
	input wire logic flow_auto_in,
	input wire logic rts_sw_in,
	input wire logic dtr_sw_in,
	input wire logic [uart_pkg::LVL_W-1:0] rx_trig_in,
	input wire logic [uart_pkg::LVL_W-1:0] tx_trig_in,
	input wire logic [uart_pkg::LVL_W-1:0] rts_trig_in,
	input wire logic [uart_pkg::IRQ_W-1:0] irq_en_in,
	input wire logic err_clr_in,
	input wire logic tx_wr_in,
	input wire logic [7:0] tx_data_in,
	input wire logic rx_rd_in,
	input wire logic rxd_in,
	input wire logic cts_n_in,
	input wire logic dsr_n_in,
	input wire logic ri_n_in,
	input wire logic dcd_n_in,
	output logic txd_out,
	output logic rts_n_out,
	output logic dtr_n_out,
	output logic [3:0] modem_out,
	output logic tx_full_out,
	output logic rx_empty_out,
	output logic [uart_pkg::LVL_W-1:0] tx_level_out,
	output logic [uart_pkg::LVL_W-1:0] rx_level_out,
	output logic [7:0] rx_data_out,
	output logic [uart_pkg::STAT_W-1:0] rx_stat_out,
	output logic rx_valid_out,
	output logic tx_idle_out,
	output logic rx_err_out,
	output logic tx_almost_empty_out,
	output logic rx_almost_full_out,
	output logic irq_out
);
	localparam int MAXD = USE_STAT ? uart_pkg::DEPTH_MAX_STAT : uart_pkg::DEPTH_MAX;
	localparam int TXD = TX_DEPTH < uart_pkg::DEPTH_MIN ? uart_pkg::DEPTH_MIN :
		(TX_DEPTH > MAXD ? MAXD : TX_DEPTH);
	localparam int RXD = RX_DEPTH < uart_pkg::DEPTH_MIN ? uart_pkg::DEPTH_MIN :
		(RX_DEPTH > MAXD ? MAXD : RX_DEPTH);
	localparam int TAW = $clog2(TXD);
	localparam int RAW = $clog2(RXD);
	localparam int CW = uart_pkg::CNT_W;

	typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} tx_state_e;
	typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP, R_WAIT} rx_state_e;

	logic [uart_pkg::DIV_W-1:0] baud_q;
	logic [uart_pkg::SAMP_W-1:0] samp_q;
	logic [1:0] len_q, stop_q;
	logic [2:0] par_q;
	logic brk_q, flow_q, rts_sw_q, dtr_sw_q, rx_err_q;
	logic [uart_pkg::LVL_W-1:0] rxtrig_q, txtrig_q, rtstrig_q;
	logic [uart_pkg::IRQ_W-1:0] ien_q, cond;
	logic tick, cts_ok, start_ok, tx_idle;
	logic [CW-1:0] bit_end, half_end, stop_end;
	logic [2:0] last_bit;
	logic [uart_pkg::LVL_W-1:0] tx_lvl, rx_lvl;
	tx_state_e tstate_q;
	rx_state_e rstate_q;
	logic [CW-1:0] tcnt_q, rcnt_q;
	logic [2:0] tbit_q, rbit_q;
	logic [7:0] tsh_q, rsh_q, rx_char, rxw_q;
	logic tpar_q, rx_s1_q, rx_s2_q, rx_f, zero_q, perr_q, rx_push_q;
	logic [2:0] flt_q;
	logic [uart_pkg::STAT_W-1:0] stw_q, last_stat_q;

	fifo_if #(.W(8), .AW(TAW)) tx_if();
	fifo_if #(.W(8), .AW(RAW)) rx_if();
	fifo_if #(.W(uart_pkg::STAT_W), .AW(RAW)) st_if();

	flop_fifo #(.W(8), .DEPTH(TXD), .AW(TAW)) u_tx_fifo (
		.mclk_in(mclk_in), .nrst_in(nrst_in), .f(tx_if.store));
	flop_fifo #(.W(8), .DEPTH(RXD), .AW(RAW)) u_rx_fifo (
		.mclk_in(mclk_in), .nrst_in(nrst_in), .f(rx_if.store));
	baud_gen #(.DW(uart_pkg::DIV_W)) u_baud (
		.mclk_in(mclk_in), .nrst_in(nrst_in), .clear_in(soft_rst_in),
		.div_in(baud_q), .tick_out(tick));

	// status fifo runs in step with the data fifo when it is built
	generate
		if (USE_STAT) begin : g_stat
			flop_fifo #(.W(uart_pkg::STAT_W), .DEPTH(RXD), .AW(RAW)) u_st_fifo (
				.mclk_in(mclk_in), .nrst_in(nrst_in), .f(st_if.store));
		end else begin : g_nostat
			assign st_if.rdata = last_stat_q;
			assign st_if.full = 1'b0;
			assign st_if.empty = 1'b0;
			assign st_if.level = '0;
		end
	endgenerate

	// processor side of the fifos and the receive push; the transmit pop is driven below
	assign tx_if.push = tx_wr_in;
	assign tx_if.wdata = tx_data_in;
	assign tx_if.flush = soft_rst_in || tx_ptr_rst_in;
	assign rx_if.pop = rx_rd_in;
	assign rx_if.push = rx_push_q;
	assign rx_if.wdata = rxw_q;
	assign rx_if.flush = soft_rst_in || rx_ptr_rst_in;
	assign st_if.pop = rx_rd_in;
	assign st_if.push = rx_push_q;
	assign st_if.wdata = stw_q;
	assign st_if.flush = soft_rst_in || rx_ptr_rst_in;

	// bit timing in ticks: one bit is samp_q ticks
	assign bit_end = CW'(samp_q) - 1'b1;
	assign half_end = CW'(samp_q >> 1);
	always_comb begin
		unique case (stop_q)
			uart_pkg::STOP_ONE_HALF: stop_end = CW'(samp_q) + CW'(samp_q >> 1) - 1'b1;
			uart_pkg::STOP_TWO: stop_end = CW'({samp_q, 1'b0}) - 1'b1;
			default: stop_end = bit_end;
		endcase
	end
	assign last_bit = 3'h4 + 3'(len_q);
	assign tx_lvl = uart_pkg::LVL_W'(tx_if.level);
	assign rx_lvl = uart_pkg::LVL_W'(rx_if.level);
	assign cts_ok = !flow_q || !cts_n_in;
	assign start_ok = !tx_if.empty && !brk_q && cts_ok;
	assign tx_if.pop = (tstate_q == T_IDLE) && start_ok;
	assign tx_idle = (tstate_q == T_IDLE) && tx_if.empty;

	// settings: parameters at reset, ports on a configuration strobe
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			baud_q <= INIT_BAUD_DIV;
			samp_q <= INIT_SAMPLES;
			len_q <= INIT_LEN;
			stop_q <= INIT_STOP;
			par_q <= INIT_PARITY;
			{brk_q, flow_q, rts_sw_q, dtr_sw_q} <= 4'h0;
			rxtrig_q <= INIT_RX_TRIG;
			txtrig_q <= INIT_TX_TRIG;
			rtstrig_q <= INIT_RTS_TRIG;
			ien_q <= '0;
		end else if (soft_rst_in) begin
			baud_q <= INIT_BAUD_DIV;
			samp_q <= INIT_SAMPLES;
			len_q <= INIT_LEN;
			stop_q <= INIT_STOP;
			par_q <= INIT_PARITY;
			{brk_q, flow_q, rts_sw_q, dtr_sw_q} <= 4'h0;
			rxtrig_q <= INIT_RX_TRIG;
			txtrig_q <= INIT_TX_TRIG;
			rtstrig_q <= INIT_RTS_TRIG;
			ien_q <= '0;
		end else if (cfg_wr_in) begin
			baud_q <= baud_div_in;
			// too few samples leave no middle to sample at
			samp_q <= samples_in < uart_pkg::SAMP_MIN ? uart_pkg::SAMP_MIN : samples_in;
			len_q <= data_len_in;
			stop_q <= stop_sel_in;
			par_q <= parity_in;
			brk_q <= break_in;
			flow_q <= flow_auto_in;
			rts_sw_q <= rts_sw_in;
			dtr_sw_q <= dtr_sw_in;
			rxtrig_q <= rx_trig_in;
			txtrig_q <= tx_trig_in;
			rtstrig_q <= rts_trig_in;
			ien_q <= irq_en_in;
		end
	end

	// transmit sequencer; a character starts only from idle
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tstate_q <= T_IDLE;
			tcnt_q <= '0;
			tbit_q <= '0;
			tsh_q <= '0;
			tpar_q <= 1'b0;
		end else if (soft_rst_in) begin
			tstate_q <= T_IDLE;
			tcnt_q <= '0;
		end else begin
			unique case (tstate_q)
				T_IDLE: if (start_ok) begin
					tsh_q <= tx_if.rdata & uart_pkg::len_mask(len_q);
					tpar_q <= uart_pkg::par_bit(tx_if.rdata, len_q, par_q);
					tcnt_q <= '0;
					tstate_q <= T_START;
				end
				T_START: if (tick) begin
					tcnt_q <= (tcnt_q == bit_end) ? '0 : tcnt_q + 1'b1;
					if (tcnt_q == bit_end) begin
						tbit_q <= '0;
						tstate_q <= T_DATA;
					end
				end
				T_DATA: if (tick) begin
					tcnt_q <= (tcnt_q == bit_end) ? '0 : tcnt_q + 1'b1;
					if (tcnt_q == bit_end) begin
						tsh_q <= tsh_q >> 1;
						tbit_q <= tbit_q + 1'b1;
						if (tbit_q == last_bit) begin
							tstate_q <= (par_q == uart_pkg::PAR_NONE) ? T_STOP : T_PAR;
						end
					end
				end
				T_PAR: if (tick) begin
					tcnt_q <= (tcnt_q == bit_end) ? '0 : tcnt_q + 1'b1;
					if (tcnt_q == bit_end) begin
						tstate_q <= T_STOP;
					end
				end
				T_STOP: if (tick) begin
					tcnt_q <= (tcnt_q == stop_end) ? '0 : tcnt_q + 1'b1;
					if (tcnt_q == stop_end) begin
						tstate_q <= T_IDLE;
					end
				end
			endcase
		end
	end

	// line level follows the state one cycle later; break overrides all
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			txd_out <= 1'b1;
		end else if (brk_q) begin
			txd_out <= 1'b0;
		end else begin
			unique case (tstate_q)
				T_START: txd_out <= 1'b0;
				T_DATA: txd_out <= tsh_q[0];
				T_PAR: txd_out <= tpar_q;
				default: txd_out <= 1'b1;
			endcase
		end
	end

	// two-flop synchroniser then a three-sample majority filter
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			flt_q <= 3'h7;
		end else begin
			rx_s1_q <= rxd_in;
			rx_s2_q <= rx_s1_q;
			if (tick) begin
				flt_q <= {flt_q[1:0], rx_s2_q};
			end
		end
	end
	assign rx_f = (flt_q[0] & flt_q[1]) | (flt_q[1] & flt_q[2]) | (flt_q[0] & flt_q[2]);
	assign rx_char = (rsh_q >> (2'h3 - len_q)) & uart_pkg::len_mask(len_q);

	// receive sequencer: mid-bit sampling, checks in the stop bit
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rstate_q <= R_IDLE;
			{rcnt_q, rbit_q, rsh_q, rxw_q, stw_q} <= '0;
			{zero_q, perr_q, rx_push_q} <= 3'h0;
		end else if (soft_rst_in) begin
			rstate_q <= R_IDLE;
			rx_push_q <= 1'b0;
		end else begin
			rx_push_q <= 1'b0;
			if (tick) begin
				rcnt_q <= (rcnt_q == bit_end) ? '0 : rcnt_q + 1'b1;
				unique case (rstate_q)
					R_IDLE: begin
						rcnt_q <= '0;
						if (!rx_f) begin
							rstate_q <= R_START;
						end
					end
					R_START: if (rcnt_q == half_end) begin
						rcnt_q <= '0;
						rbit_q <= '0;
						zero_q <= 1'b1;
						perr_q <= 1'b0;
						rstate_q <= rx_f ? R_IDLE : R_DATA; // glitch rejected
					end
					R_DATA: if (rcnt_q == bit_end) begin
						rsh_q <= {rx_f, rsh_q[7:1]};
						zero_q <= zero_q & !rx_f;
						rbit_q <= rbit_q + 1'b1;
						if (rbit_q == last_bit) begin
							rstate_q <= (par_q == uart_pkg::PAR_NONE) ? R_STOP : R_PAR;
						end
					end
					R_PAR: if (rcnt_q == bit_end) begin
						perr_q <= rx_f != uart_pkg::par_bit(rx_char, len_q, par_q);
						zero_q <= zero_q & !rx_f;
						rstate_q <= R_STOP;
					end
					R_STOP: if (rcnt_q == bit_end) begin
						rxw_q <= rx_char;
						stw_q[uart_pkg::ST_PAR] <= perr_q;
						stw_q[uart_pkg::ST_FRAME] <= !rx_f;
						stw_q[uart_pkg::ST_BREAK] <= zero_q & !rx_f;
						rx_push_q <= 1'b1;
						// a break holds the line low; wait for it to rise
						rstate_q <= rx_f ? R_IDLE : R_WAIT;
					end
					R_WAIT: if (rx_f) begin
						rstate_q <= R_IDLE;
					end
					default: rstate_q <= R_IDLE;
				endcase
			end
		end
	end

	// status flags, levels and line controls, all registered
	assign cond[uart_pkg::IRQ_RX_TRIG] = rx_lvl >= rxtrig_q;
	assign cond[uart_pkg::IRQ_TX_TRIG] = tx_lvl <= txtrig_q;
	assign cond[uart_pkg::IRQ_TX_IDLE] = tx_idle;
	assign cond[uart_pkg::IRQ_RX_ERR] = rx_err_q;
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			{irq_out, rx_err_q, rx_err_out, rx_valid_out, tx_full_out} <= 5'h00;
			{rx_empty_out, tx_idle_out, tx_almost_empty_out} <= 3'h7;
			{rx_almost_full_out, rts_n_out, dtr_n_out} <= 3'h3;
			{tx_level_out, rx_level_out, rx_data_out, rx_stat_out, modem_out} <= '0;
			last_stat_q <= '0;
		end else begin
			irq_out <= |(cond & ien_q);
			// a new error in the clearing cycle still sets the flag
			rx_err_q <= (rx_err_q && !err_clr_in && !soft_rst_in) ||
				(rx_push_q && stw_q != '0);
			rx_err_out <= rx_err_q;
			if (rx_push_q) begin
				last_stat_q <= stw_q;
			end
			rx_valid_out <= rx_rd_in && !rx_if.empty;
			if (rx_rd_in && !rx_if.empty) begin
				rx_data_out <= rx_if.rdata;
				rx_stat_out <= st_if.rdata;
			end
			tx_full_out <= tx_if.full;
			rx_empty_out <= rx_if.empty;
			tx_level_out <= tx_lvl;
			rx_level_out <= rx_lvl;
			tx_idle_out <= tx_idle;
			tx_almost_empty_out <= tx_lvl <= txtrig_q;
			rx_almost_full_out <= rx_lvl >= rxtrig_q;
			rts_n_out <= flow_q ? (rx_lvl >= rtstrig_q) : !rts_sw_q;
			dtr_n_out <= !dtr_sw_q;
			modem_out <= {!cts_n_in, !dcd_n_in, !ri_n_in, !dsr_n_in};
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);

	chk_break_line: assert property (brk_q |=> !txd_out) else $error("break not driven");
	chk_start_low: assert property ($rose(tstate_q == T_START) && !brk_q |=> !txd_out)
		else $error("start bit not low");
	chk_idle_high: assert property (tstate_q == T_IDLE && !brk_q |=> txd_out)
		else $error("idle line not high");
	chk_irq_level: assert property (irq_out == $past(|(cond & ien_q)))
		else $error("interrupt level wrong");
	chk_irq_hold: assert property ((|(cond & ien_q))[*2] |-> irq_out)
		else $error("interrupt dropped");
	chk_cts_block: assert property (flow_q && cts_n_in && tstate_q == T_IDLE |=>
		tstate_q == T_IDLE) else $error("sent without clear to send");
	chk_idle_meaning: assert property (tx_idle_out |-> $past(tx_if.empty))
		else $error("idle with data pending");
	chk_dma_levels: assert property (##1 tx_almost_empty_out == ($past(tx_lvl) <= $past(txtrig_q))
		&& rx_almost_full_out == ($past(rx_lvl) >= $past(rxtrig_q)))
		else $error("dma level wrong");
	chk_rx_push: assert property (rx_push_q |=> rx_if.level != '0 || $past(rx_if.full)
		|| $past(rx_if.flush)) else $error("received char lost");
	chk_ptr_reset: assert property (tx_ptr_rst_in |=> tx_if.empty)
		else $error("tx pointers not reset");

	cov_tx_char: cover property ($fell(tstate_q == T_STOP));
	cov_rx_break: cover property (rx_push_q && stw_q[uart_pkg::ST_BREAK]);
	cov_parity_err: cover property (rx_push_q && stw_q[uart_pkg::ST_PAR]);
	cov_irq: cover property ($rose(irq_out));
endmodule
`default_nettype wire

/* File: rtl/uart_pkg.sv */
// constants, encodings and shared helpers of the serial transceiver
package uart_pkg;
	localparam int DIV_W = 20;
	localparam int SAMP_W = 5;
	localparam int LVL_W = 11;
	localparam int CNT_W = 6;
	localparam int DEPTH_MIN = 16;
	localparam int DEPTH_MAX = 1024;
	localparam int DEPTH_MAX_STAT = 512;
	localparam int STAT_W = 3;
	localparam logic [SAMP_W-1:0] SAMP_MIN = 5'h04;
	// parity modes
	localparam logic [2:0] PAR_NONE = 3'h0;
	localparam logic [2:0] PAR_EVEN = 3'h1;
	localparam logic [2:0] PAR_ODD = 3'h2;
	localparam logic [2:0] PAR_SPACE = 3'h3;
	localparam logic [2:0] PAR_MARK = 3'h4;
	// stop lengths
	localparam logic [1:0] STOP_ONE = 2'h0;
	localparam logic [1:0] STOP_ONE_HALF = 2'h1;
	localparam logic [1:0] STOP_TWO = 2'h2;
	// data length code: 0..3 stands for 5..8 bits
	localparam logic [1:0] LEN_8 = 2'h3;
	// status entry bit positions
	localparam int ST_PAR = 0;
	localparam int ST_FRAME = 1;
	localparam int ST_BREAK = 2;
	// interrupt condition positions
	localparam int IRQ_RX_TRIG = 0;
	localparam int IRQ_TX_TRIG = 1;
	localparam int IRQ_TX_IDLE = 2;
	localparam int IRQ_RX_ERR = 3;
	localparam int IRQ_W = 4;
	// reset values of the programmable settings
	localparam logic [DIV_W-1:0] RST_BAUD_DIV = 20'h0001A;
	localparam logic [SAMP_W-1:0] RST_SAMPLES = 5'h10;
	localparam logic [1:0] RST_LEN = 2'h3;
	localparam logic [1:0] RST_STOP = 2'h0;
	localparam logic [2:0] RST_PARITY = 3'h0;
	localparam logic [LVL_W-1:0] RST_RX_TRIG = 11'h008;
	localparam logic [LVL_W-1:0] RST_TX_TRIG = 11'h004;
	localparam logic [LVL_W-1:0] RST_RTS_TRIG = 11'h00C;

	// keeps only the bits of the programmed character length
	function automatic logic [7:0] len_mask(input logic [1:0] len);
		return 8'hFF >> (2'h3 - len);
	endfunction

	// parity bit for a character, shared by transmit and receive check
	function automatic logic par_bit(input logic [7:0] d, input logic [1:0] len,
			input logic [2:0] mode);
		logic x;
		x = ^(d & len_mask(len));
		case (mode)
			PAR_EVEN: return x;
			PAR_ODD: return ~x;
			PAR_MARK: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
endpackage

/* File: rtl/fifo_if.sv */
// two-sided fifo connection: one port per side, plus flush and fill level
`timescale 1ns/1ps
`default_nettype none
interface fifo_if #(parameter int W = 8, parameter int AW = 4);
	logic push;
	logic [W-1:0] wdata;
	logic pop;
	logic flush;
	logic [W-1:0] rdata;
	logic full;
	logic empty;
	logic [AW:0] level;
	modport store(input push, wdata, pop, flush, output rdata, full, empty, level);
	modport user(output push, wdata, pop, flush, input rdata, full, empty, level);
endinterface
`default_nettype wire

/* File: rtl/flop_fifo.sv */
// flip-flop fifo, write and read sides usable in the same cycle
`timescale 1ns/1ps
`default_nettype none
module flop_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic mclk_in,
	input wire logic nrst_in,
	fifo_if.store f
);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic do_push;
	logic do_pop;

	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// full refuses a push; an empty fifo ignores a pop
	assign do_push = f.push && !f.full;
	assign do_pop = f.pop && !f.empty;
	assign f.rdata = mem_q[rd_q];
	assign f.full = (cnt_q == (AW + 1)'(DEPTH));
	assign f.empty = (cnt_q == '0);
	assign f.level = cnt_q;

	// storage needs no reset, only the pointers decide what is valid
	always_ff @(posedge mclk_in) begin
		if (do_push) begin
			mem_q[wr_q] <= f.wdata;
		end
	end

	// pointers and count; both sides move independently
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (f.flush) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (do_push) begin
				wr_q <= nxt(wr_q);
			end
			if (do_pop) begin
				rd_q <= nxt(rd_q);
			end
			cnt_q <= cnt_q + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
		end
	end

	chk_level_bound: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		cnt_q <= (AW + 1)'(DEPTH)) else $error("fifo count above depth");
endmodule
`default_nettype wire

/* File: rtl/baud_gen.sv */
// programmable divider producing the oversampling tick
`timescale 1ns/1ps
`default_nettype none
module baud_gen #(
	parameter int DW = uart_pkg::DIV_W
) (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic clear_in,
	input wire logic [DW-1:0] div_in,
	output logic tick_out
);
	logic [DW-1:0] cnt_q;

	// tick every div+1 cycles; a new divisor takes effect at once, as the count is compared with it every cycle
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_q <= '0;
			tick_out <= 1'b0;
		end else if (clear_in || cnt_q >= div_in) begin
			cnt_q <= '0;
			tick_out <= !clear_in;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			tick_out <= 1'b0;
		end
	end

	chk_tick_spacing: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		tick_out && div_in != '0 && $stable(div_in) |=> !tick_out)
		else $error("baud ticks too close");
endmodule
`default_nettype wire

/* File: sim/serial_node.sv */
// remote serial node: sends frames to the design and captures its frames
`timescale 1ns/1ps
`default_nettype none
module serial_node #(parameter int BIT = 8) (
	input wire logic mclk_in,
	input wire logic txd_in,
	output logic rxd_out
);
	initial rxd_out = 1'b1;
	// start, data lsb first, parity, stop; line back high after
	task automatic send(input logic [7:0] v, input logic pb, input logic stb);
		logic [10:0] f;
		f = {stb, pb, v, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge mclk_in) rxd_out <= f[i];
			repeat (BIT - 1) @(posedge mclk_in);
		end
		@(posedge mclk_in) rxd_out <= 1'b1;
		repeat (2 * BIT) @(posedge mclk_in);
	endtask
	// mid-bit sampling after the start edge; ninth sample is parity or stop
	task automatic recv(output logic [7:0] v, output logic pb);
		for (int n = 0; n < 3000 && txd_in !== 1'b0; n++) @(posedge mclk_in);
		repeat (BIT / 2) @(posedge mclk_in);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT) @(posedge mclk_in);
			if (i < 8) v[i] = txd_in;
			else pb = txd_in;
		end
	endtask
endmodule
`default_nettype wire

/* File: sim/lin_uart_tb_top.sv */
// self-checking bench: settings, frames both ways, modem lines and break
`timescale 1ns/1ps
`default_nettype none
module lin_uart_tb_top;
	logic mclk_in = 1'b0;
	logic nrst_in, soft_rst_in, rx_ptr_rst_in, tx_ptr_rst_in, cfg_wr_in, break_in;
	logic flow_auto_in, rts_sw_in, dtr_sw_in, err_clr_in, tx_wr_in, rx_rd_in, rxd_in;
	logic cts_n_in, dsr_n_in, ri_n_in, dcd_n_in, txd_out, rts_n_out, dtr_n_out;
	logic tx_full_out, rx_empty_out, rx_valid_out, tx_idle_out, rx_err_out, irq_out;
	logic tx_almost_empty_out, rx_almost_full_out, p;
	logic [uart_pkg::DIV_W-1:0] baud_div_in;
	logic [uart_pkg::SAMP_W-1:0] samples_in;
	logic [1:0] data_len_in, stop_sel_in;
	logic [2:0] parity_in;
	logic [uart_pkg::STAT_W-1:0] rx_stat_out;
	logic [uart_pkg::LVL_W-1:0] rx_trig_in, tx_trig_in, rts_trig_in, tx_level_out, rx_level_out;
	logic [uart_pkg::IRQ_W-1:0] irq_en_in;
	logic [3:0] modem_out;
	logic [7:0] tx_data_in, rx_data_out, d, x;
	int mismatches = 0;
	int cmp_count = 0;
	// 50 MHz clock
	always #10 mclk_in = ~mclk_in;
	lin_uart DUT (.*);
	serial_node #(.BIT(8)) node (.mclk_in(mclk_in), .txd_in(txd_out), .rxd_out(rxd_in));
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			mismatches++;
			$display("unexpected at %0t: saw %0h want %0h", $time, seen, want);
		end
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// bounded wait, so a stuck flag ends in a mismatch, not a hang
	task automatic wait_lvl(ref logic s, input logic v);
		for (int n = 0; n < 3000 && s !== v; n++) @(posedge mclk_in);
	endtask
	task automatic cfg(input logic [2:0] par, input logic brk);
		@(posedge mclk_in);
		parity_in <= par;
		break_in <= brk;
		@(posedge mclk_in) cfg_wr_in <= 1'b1;
		@(posedge mclk_in) cfg_wr_in <= 1'b0;
	endtask
	// one frame in, one pop, data and masked status compared
	task automatic rx_one(input logic [7:0] v, input logic pb, input logic stb,
			input logic [2:0] m, input logic [2:0] e);
		node.send(v, pb, stb);
		wait_lvl(rx_empty_out, 1'b0);
		repeat (2) @(posedge mclk_in);
		#1 check({irq_out, rx_almost_full_out, rx_level_out}, 13'h1801);
		@(posedge mclk_in) rx_rd_in <= 1'b1;
		@(posedge mclk_in) rx_rd_in <= 1'b0;
		// valid stands only in the cycle after the accepted pop
		#1 check(rx_valid_out, 1'b1);
		check(rx_data_out, v);
		check(rx_stat_out & m, e);
	endtask
	// watchdog: the run needs well under 3000 cycles
	initial begin
		repeat (20000) @(posedge mclk_in);
		mismatches++;
		stop_test();
	end
	initial begin
		{nrst_in, soft_rst_in, rx_ptr_rst_in, tx_ptr_rst_in, cfg_wr_in, break_in} = '0;
		{flow_auto_in, rts_sw_in, err_clr_in, tx_wr_in, rx_rd_in, cts_n_in, dsr_n_in} = '0;
		{ri_n_in, dcd_n_in, dtr_sw_in} = 3'h7;
		baud_div_in = '0;
		samples_in = 5'h08;
		data_len_in = uart_pkg::LEN_8;
		stop_sel_in = uart_pkg::STOP_ONE;
		parity_in = uart_pkg::PAR_NONE;
		{rx_trig_in, tx_trig_in, rts_trig_in} = {11'h001, 11'h000, 11'h002};
		irq_en_in = 4'h1;
		tx_data_in = '0;
		repeat (10) @(posedge mclk_in);
		nrst_in <= 1'b1;
		@(posedge mclk_in);
		#1 check({txd_out, rts_n_out, dtr_n_out, rx_empty_out, tx_idle_out, irq_out}, 6'h3E);
		cfg(uart_pkg::PAR_NONE, 1'b0);
		repeat (3) @(posedge mclk_in);
		#1 check({dtr_n_out, modem_out}, 5'h09);
		// all parity modes; with none the ninth sample is the stop bit
		for (int i = 0; i < 5; i++) begin
			x = 8'hA4 + 8'(i);
			cfg(3'(i), 1'b0);
			@(posedge mclk_in) tx_data_in <= x;
			fork
				node.recv(d, p);
				begin
					@(posedge mclk_in) tx_wr_in <= 1'b1;
					@(posedge mclk_in) tx_wr_in <= 1'b0;
				end
			join
			check(d, x);
			check(p, i == 2 ? ~^x : i == 1 ? ^x : i != 3);
			wait_lvl(tx_idle_out, 1'b1);
			#1 check(tx_idle_out, 1'b1);
		end
		cfg(uart_pkg::PAR_EVEN, 1'b0);
		rx_one(8'h3C, 1'b0, 1'b1, 3'h7, 3'h0);
		check(rx_err_out, 1'b0);
		rx_one(8'h81, 1'b0, 1'b0, 3'h2, 3'h2);
		rx_one(8'h81, 1'b1, 1'b1, 3'h7, 3'h1);
		rx_one(8'h00, 1'b0, 1'b0, 3'h4, 3'h4);
		check(rx_err_out, 1'b1);
		cfg(uart_pkg::PAR_EVEN, 1'b1);
		repeat (3) @(posedge mclk_in);
		#1 check(txd_out, 1'b0);
		// break holds the transmitter, so pushed bytes stay counted
		@(posedge mclk_in) tx_wr_in <= 1'b1;
		repeat (2) @(posedge mclk_in);
		tx_wr_in <= 1'b0;
		@(posedge mclk_in);
		#1 check({tx_almost_empty_out, tx_level_out}, 12'h002);
		@(posedge mclk_in) tx_ptr_rst_in <= 1'b1;
		@(posedge mclk_in) tx_ptr_rst_in <= 1'b0;
		@(posedge mclk_in);
		#1 check({tx_almost_empty_out, tx_level_out}, 12'h800);
		cfg(uart_pkg::PAR_EVEN, 1'b0);
		repeat (3) @(posedge mclk_in);
		#1 check(txd_out, 1'b1);
		@(posedge mclk_in) err_clr_in <= 1'b1;
		@(posedge mclk_in) err_clr_in <= 1'b0;
		@(posedge mclk_in);
		#1 check(rx_err_out, 1'b0);
		// channel reset drops the software terminal-ready level
		@(posedge mclk_in) soft_rst_in <= 1'b1;
		@(posedge mclk_in) soft_rst_in <= 1'b0;
		@(posedge mclk_in);
		#1 check({dtr_n_out, txd_out}, 2'h3);
		stop_test();
	end
endmodule
`default_nettype wire
